/* File: test/cmau_rf_model.sv */
`timescale 1ns/1ns
module cmau_rf_model (
    input  wire logic        clk,
    input  wire logic        src_sel_valid,
    input  wire logic [3:0]  src_sel,
    input  wire logic [3:0]  operand_sel,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic        aux_wr_en,
    input  wire logic [15:0] aux_wr_data,
    output logic      [15:0] src_value,
    output logic      [15:0] operand_value,
    output logic      [15:0] signed_byte_multiply_value
);
    logic [15:0] regs [16];
    // no prefix selects register zero
    assign src_value     = regs[src_sel_valid ? src_sel : cmau_pkg::CMAU_DEFAULT_REG];
    assign operand_value = regs[operand_sel];
    assign signed_byte_multiply_value    = regs[cmau_pkg::CMAU_SIGNED_BYTE_MULTIPLY_REG];
    always @(posedge clk) begin
        if (wr_en)
            regs[wr_addr] <= wr_data;
        if (aux_wr_en)
            regs[cmau_pkg::CMAU_AUX_REG] <= aux_wr_data;
    end
endmodule // cmau_rf_model

/* File: test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic                  clk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  op_valid = 1'b0;
    cmau_pkg::cmau_op_type op_code = cmau_pkg::CMAU_OP_NONE;
    logic                  src_sel_valid = 1'b0;
    logic                  dst_sel_valid = 1'b0;
    logic [3:0]            src_sel = 4'h0;
    logic [3:0]            dst_sel = 4'h0;
    logic [3:0]            operand_sel = 4'h0;
    logic [7:0]            core_config_register = 8'h00;
    logic                  alternate_mode_flag_one_prefix = 1'b0;
    logic                  alternate_mode_flag_two_prefix = 1'b0;
    logic                  carry_flag_in = 1'b0;
    logic                  busy, done, wr_en, aux_wr_en;
    logic [3:0]            wr_addr, src_idx, dst_idx;
    logic [15:0]           src_value, operand_value, signed_byte_multiply_value;
    logic [15:0]           wr_data, aux_wr_data, status_flags;
    int                    num_errors = 0;
    int                    comparisons = 0;

    always #5 clk = ~clk;

    cmau_unit dut (
        .clk(clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
        .src_sel_valid(src_sel_valid), .src_sel(src_sel), .dst_sel_valid(dst_sel_valid),
        .dst_sel(dst_sel), .operand_sel(operand_sel), .src_value(src_value),
        .operand_value(operand_value), .signed_byte_multiply_value(signed_byte_multiply_value),
        .core_config_register(core_config_register), .alternate_mode_flag_one_prefix(alternate_mode_flag_one_prefix),
        .alternate_mode_flag_two_prefix(alternate_mode_flag_two_prefix), .carry_flag_in(carry_flag_in), .busy(busy),
        .done(done), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .aux_wr_en(aux_wr_en), .aux_wr_data(aux_wr_data), .src_idx(src_idx),
        .dst_idx(dst_idx), .status_flags(status_flags));

    cmau_rf_model pm (
        .clk(clk), .src_sel_valid(src_sel_valid), .src_sel(src_sel),
        .operand_sel(operand_sel), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .aux_wr_en(aux_wr_en), .aux_wr_data(aux_wr_data), .src_value(src_value),
        .operand_value(operand_value), .signed_byte_multiply_value(signed_byte_multiply_value));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // issue one op, wait for done, judge the latency
    task automatic run(input cmau_pkg::cmau_op_type op, input logic [3:0] s, d, o,
                       input logic sv, dv, input int lat);
        int n;
        @(negedge clk);
        op_valid = 1'b1;
        op_code = op;
        src_sel = s;
        dst_sel = d;
        operand_sel = o;
        src_sel_valid = sv;
        dst_sel_valid = dv;
        @(negedge clk);
        op_valid = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(n, lat);
        if (n == 20)
            tally_and_finish();
    endtask

    task automatic t_byte();
        logic [15:0] a [3] = '{16'h1280, 16'h00ff, 16'hab7f};
        logic [15:0] b [3] = '{16'h347f, 16'h77ff, 16'h0081};
        for (int i = 0; i < 3; i++) begin
            pm.regs[2] = a[i];
            pm.regs[9] = b[i];
            run(cmau_pkg::CMAU_OP_SMUL, 4'h2, 4'h7, 4'h9, 1'b1, 1'b1, 1);
            check({wr_en, wr_addr, wr_data},
                  {1'b1, 4'h7, 16'($signed(a[i][7:0]) * $signed(b[i][7:0]))});
            run(cmau_pkg::CMAU_OP_UMUL, 4'h2, 4'h7, 4'h9, 1'b1, 1'b1, 1);
            check({wr_en, wr_addr, wr_data}, {1'b1, 4'h7, 16'(a[i][7:0] * b[i][7:0])});
        end
    endtask

    task automatic t_long(input logic fast, input int lat);
        logic [15:0] a [3] = '{16'h8001, 16'h7fff, 16'hffff};
        logic [15:0] m [3] = '{16'h7fff, 16'hff80, 16'hffff};
        logic [31:0] p;
        core_config_register = {2'b00, fast, 5'h00};
        for (int i = 0; i < 3; i++) begin
            p = $signed(a[i]) * $signed(m[i]);
            pm.regs[3] = a[i];
            pm.regs[6] = m[i];
            run(cmau_pkg::CMAU_OP_LMUL, 4'h3, 4'h5, 4'h0, 1'b1, 1'b1, lat);
            check({busy, wr_en, aux_wr_en, wr_addr}, {1'b0, 1'b1, 1'b1, 4'h5});
            check({wr_data, aux_wr_data}, p);
            run(cmau_pkg::CMAU_OP_LMUL, 4'h3, 4'h4, 4'h0, 1'b1, 1'b1, lat);
            check({wr_en, aux_wr_en, aux_wr_data}, {1'b0, 1'b1, p[31:16]});
            run(cmau_pkg::CMAU_OP_FMUL, 4'h3, 4'h5, 4'h0, 1'b1, 1'b1, lat);
            check({wr_en, aux_wr_en, wr_addr, wr_data}, {2'b10, 4'h5, p[31:16]});
            pm.regs[4] = ~p[31:16];
            run(cmau_pkg::CMAU_OP_FMUL, 4'h3, 4'h4, 4'h0, 1'b1, 1'b1, lat);
            check({wr_en, aux_wr_en}, 2'b00);
            @(negedge clk);
            check(pm.regs[4], 16'(~p[31:16]));
        end
    endtask

    task automatic t_add();
        cmau_pkg::cmau_op_type op [5] = '{cmau_pkg::CMAU_OP_ADD, cmau_pkg::CMAU_OP_ADC,
            cmau_pkg::CMAU_OP_ADCI, cmau_pkg::CMAU_OP_ADC, cmau_pkg::CMAU_OP_ADD};
        logic [15:0] s [5] = '{16'h7fff, 16'hffff, 16'h7ff4, 16'h8000, 16'h4283};
        logic [15:0] o [5] = '{16'h0001, 16'h0000, 16'h0000, 16'h8000, 16'h2438};
        logic [15:0] opd;
        logic [16:0] r;
        logic        ovf;
        carry_flag_in = 1'b1;
        for (int i = 0; i < 5; i++) begin
            pm.regs[0] = s[i];
            pm.regs[11] = o[i];
            // immediate form takes operand_sel itself
            opd = (op[i] == cmau_pkg::CMAU_OP_ADCI) ? 16'h000b : o[i];
            r = {1'b0, s[i]} + {1'b0, opd} + {16'h0000, op[i] != cmau_pkg::CMAU_OP_ADD};
            ovf = (s[i][15] == opd[15]) && (r[15] != s[i][15]);
            run(op[i], 4'h9, 4'h8, 4'hb, 1'b0, i != 4, 1);
            check({wr_en, wr_addr, wr_data, src_idx, dst_idx},
                  {1'b1, (i == 4) ? 4'h0 : 4'h8, r[15:0], 4'h0,
                   (i == 4) ? 4'h0 : 4'h8});
            check(status_flags, {12'h000, ovf, r[15], r[16], r[15:0] == 16'h0000});
        end
    endtask

    task automatic t_alt();
        @(negedge clk);
        alternate_mode_flag_one_prefix = 1'b1;
        @(negedge clk);
        alternate_mode_flag_one_prefix = 1'b0;
        check(status_flags[9:8], 2'b01);
        alternate_mode_flag_two_prefix = 1'b1;
        @(negedge clk);
        alternate_mode_flag_two_prefix = 1'b0;
        check(status_flags[9:8], 2'b11);
        run(cmau_pkg::CMAU_OP_ADD, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 1);
        check(status_flags[9:8], 2'b00);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        check({busy, done, wr_en, aux_wr_en, status_flags, src_idx, dst_idx}, 32'h0);
        t_byte();
        t_long(1'b1, 5);
        t_long(1'b0, 8);
        t_add();
        t_alt();
        tally_and_finish();
    end
endmodule // tb_top

/* File: verilog/cmau_pkg.sv */
package cmau_pkg;

    // operation codes presented by the sequencer
    typedef enum logic [2:0] {
        CMAU_OP_NONE   = 3'b000,
        CMAU_OP_SMUL   = 3'b001,
        CMAU_OP_UMUL   = 3'b010,
        CMAU_OP_LMUL   = 3'b011,
        CMAU_OP_FMUL   = 3'b100,
        CMAU_OP_ADD    = 3'b101,
        CMAU_OP_ADC    = 3'b110,
        CMAU_OP_ADCI   = 3'b111
    } cmau_op_type;

    typedef enum logic [2:0] {
        CMAU_ST_IDLE   = 3'b000,
        CMAU_ST_P1     = 3'b001,
        CMAU_ST_P2     = 3'b010,
        CMAU_ST_P3     = 3'b011,
        CMAU_ST_P4     = 3'b100,
        CMAU_ST_WAIT   = 3'b101
    } cmau_state_type;

    localparam logic [3:0] CMAU_AUX_REG      = 4'h4;
    localparam logic [3:0] CMAU_SIGNED_BYTE_MULTIPLY_REG     = 4'h6;
    localparam logic [3:0] CMAU_DEFAULT_REG  = 4'h0;
    localparam int         CMAU_CFG_SPEED_BIT = 5;
    localparam int         CMAU_ALTERNATE_MODE_FLAG_ONE_BIT      = 8;
    localparam int         CMAU_ALTERNATE_MODE_FLAG_TWO_BIT      = 9;
    localparam int         CMAU_PPB_W         = 18;
    // opcode bytes
    localparam logic [7:0] CMAU_ADD_HI       = 8'h50;
    localparam logic [7:0] CMAU_PFX_ADC      = 8'h3d;
    localparam logic [7:0] CMAU_PFX_ADCI     = 8'h3f;
    localparam logic [7:0] CMAU_PFX_ALTERNATE_MODE_FLAG_ONE     = 8'h3d;
    // extra idle cycles after each of the first three long-multiply passes in standard speed
    localparam logic [1:0] CMAU_SLOW_WAIT    = 2'h1;

endpackage

/* File: verilog/cmau_unit.sv */
`timescale 1ns/1ns
module cmau_unit (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  op_valid,
    input  wire cmau_pkg::cmau_op_type op_code,
    input  wire logic                  src_sel_valid,
    input  wire logic [3:0]            src_sel,
    input  wire logic                  dst_sel_valid,
    input  wire logic [3:0]            dst_sel,
    input  wire logic [3:0]            operand_sel,
    input  wire logic [15:0]           src_value,
    input  wire logic [15:0]           operand_value,
    input  wire logic [15:0]           signed_byte_multiply_value,
    input  wire logic [7:0]            core_config_register,
    input  wire logic                  alternate_mode_flag_one_prefix,
    input  wire logic                  alternate_mode_flag_two_prefix,
    input  wire logic                  carry_flag_in,
    output logic                       busy,
    output logic                       done,
    output logic                       wr_en,
    output logic [3:0]                 wr_addr,
    output logic [15:0]                wr_data,
    output logic                       aux_wr_en,
    output logic [15:0]                aux_wr_data,
    output logic [3:0]                 src_idx,
    output logic [3:0]                 dst_idx,
    output logic [15:0]                status_flags
);

    typedef struct packed {
        cmau_pkg::cmau_state_type st;
        logic                     fract;
        logic [3:0]               dst;
        logic [15:0]              s;
        logic [15:0]              m;
        logic [17:0]              ppb;
        logic [15:0]              aux;
        logic                     slow;
        logic [1:0]               wcnt;
        cmau_pkg::cmau_state_type ret;
        logic                     busy;
        logic                     done;
        logic                     wr_en;
        logic [3:0]               wr_addr;
        logic [15:0]              wr_data;
        logic                     aux_wr_en;
        logic [15:0]              aux_wr_data;
        logic [3:0]               src_idx;
        logic [3:0]               dst_idx;
        logic [15:0]              flags;
    } cmau_state_rec_type;

    cmau_state_rec_type r_r;
    cmau_state_rec_type r_nxt;

    logic [7:0]  ma;
    logic [7:0]  mb;
    logic        ma_sgn;
    logic        mb_sgn;
    logic [15:0] prod;
    logic [16:0] sum;
    logic [15:0] addb;
    logic        cin;
    logic        ovf;
    logic [17:0] ppb_add;

    // shared 8x8 multiplier with per-operand signedness
    always_comb begin
        logic signed [8:0]  xa;
        logic signed [8:0]  xb;
        logic signed [17:0] p;
        xa = 9'sh0;
        xb = 9'sh0;
        p = 18'sh0;
        xa = $signed({ma_sgn & ma[7], ma});
        xb = $signed({mb_sgn & mb[7], mb});
        p = xa * xb;
        prod = p[15:0];
    end

    always_comb begin
        ma = src_value[7:0];
        mb = operand_value[7:0];
        ma_sgn = (op_code == cmau_pkg::CMAU_OP_SMUL);
        mb_sgn = ma_sgn;
        unique case (r_r.st)
            cmau_pkg::CMAU_ST_P1: begin
                ma = r_r.s[7:0];
                mb = r_r.m[7:0];
                ma_sgn = 1'b0;
                mb_sgn = 1'b0;
            end
            cmau_pkg::CMAU_ST_P2: begin
                ma = r_r.s[15:8];
                mb = r_r.m[7:0];
                ma_sgn = 1'b1;
                mb_sgn = 1'b0;
            end
            cmau_pkg::CMAU_ST_P3: begin
                ma = r_r.s[7:0];
                mb = r_r.m[15:8];
                ma_sgn = 1'b0;
                mb_sgn = 1'b1;
            end
            cmau_pkg::CMAU_ST_P4: begin
                ma = r_r.s[15:8];
                mb = r_r.m[15:8];
                ma_sgn = 1'b1;
                mb_sgn = 1'b1;
            end
            default: begin
            end
        endcase
        ppb_add = r_r.ppb + {{2{prod[15]}}, prod};
    end

    // adder for the three add forms
    always_comb begin
        addb = (op_code == cmau_pkg::CMAU_OP_ADCI) ? {12'h000, operand_sel}
                                                   : operand_value;
        cin = (op_code != cmau_pkg::CMAU_OP_ADD) & carry_flag_in;
        sum = {1'b0, src_value} + {1'b0, addb} + {16'h0000, cin};
        ovf = (src_value[15] == addb[15]) && (sum[15] != src_value[15]);
    end

    always_comb begin
        logic [3:0] d;
        d = dst_sel_valid ? dst_sel : cmau_pkg::CMAU_DEFAULT_REG;
        r_nxt = r_r;
        r_nxt.done = 1'b0;
        r_nxt.wr_en = 1'b0;
        r_nxt.aux_wr_en = 1'b0;
        r_nxt.src_idx = src_sel_valid ? src_sel : cmau_pkg::CMAU_DEFAULT_REG;
        r_nxt.dst_idx = d;
        if (alternate_mode_flag_one_prefix) begin
            r_nxt.flags[cmau_pkg::CMAU_ALTERNATE_MODE_FLAG_ONE_BIT] = 1'b1;
        end
        if (alternate_mode_flag_two_prefix) begin
            r_nxt.flags[cmau_pkg::CMAU_ALTERNATE_MODE_FLAG_TWO_BIT] = 1'b1;
        end
        unique case (r_r.st)
            cmau_pkg::CMAU_ST_IDLE: begin
                if (op_valid) begin
                    unique case (op_code)
                        cmau_pkg::CMAU_OP_SMUL, cmau_pkg::CMAU_OP_UMUL: begin
                            r_nxt.wr_en = 1'b1;
                            r_nxt.wr_addr = d;
                            r_nxt.wr_data = prod;
                            r_nxt.done = 1'b1;
                        end
                        cmau_pkg::CMAU_OP_LMUL, cmau_pkg::CMAU_OP_FMUL: begin
                            r_nxt.fract = (op_code == cmau_pkg::CMAU_OP_FMUL);
                            r_nxt.dst = d;
                            r_nxt.s = src_value;
                            r_nxt.m = signed_byte_multiply_value;
                            r_nxt.ppb = '0;
                            r_nxt.slow = ~core_config_register[cmau_pkg::CMAU_CFG_SPEED_BIT];
                            r_nxt.st = cmau_pkg::CMAU_ST_P1;
                            r_nxt.busy = 1'b1;
                        end
                        cmau_pkg::CMAU_OP_ADD, cmau_pkg::CMAU_OP_ADC,
                        cmau_pkg::CMAU_OP_ADCI: begin
                            r_nxt.wr_en = 1'b1;
                            r_nxt.wr_addr = d;
                            r_nxt.wr_data = sum[15:0];
                            r_nxt.done = 1'b1;
                            r_nxt.flags = 16'h0000;
                            r_nxt.flags[0] = sum[15:0] == 16'h0000;
                            r_nxt.flags[1] = sum[16];
                            r_nxt.flags[2] = sum[15];
                            r_nxt.flags[3] = ovf;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            cmau_pkg::CMAU_ST_WAIT: begin
                r_nxt.wcnt = r_r.wcnt - 2'h1;
                if (r_r.wcnt == 2'h1) begin
                    r_nxt.st = r_r.ret;
                end
            end
            default: begin
                unique case (r_r.st)
                    cmau_pkg::CMAU_ST_P1: begin
                        r_nxt.ppb = {10'h000, prod[15:8]};
                        r_nxt.aux[7:0] = prod[7:0];
                        r_nxt.ret = cmau_pkg::CMAU_ST_P2;
                    end
                    cmau_pkg::CMAU_ST_P2: begin
                        r_nxt.ppb = ppb_add;
                        r_nxt.ret = cmau_pkg::CMAU_ST_P3;
                    end
                    cmau_pkg::CMAU_ST_P3: begin
                        r_nxt.ppb = ppb_add;
                        r_nxt.aux[15:8] = ppb_add[7:0];
                        r_nxt.ret = cmau_pkg::CMAU_ST_P4;
                    end
                    default: begin
                        r_nxt.ppb[17:8] = r_r.ppb[17:8] + prod[9:0];
                        r_nxt.ret = cmau_pkg::CMAU_ST_IDLE;
                    end
                endcase
                if (r_r.st == cmau_pkg::CMAU_ST_P4) begin
                    r_nxt.busy = 1'b0;
                    r_nxt.done = 1'b1;
                    r_nxt.st = cmau_pkg::CMAU_ST_IDLE;
                    r_nxt.wr_addr = r_r.dst;
                    // buffer counts from product bit 8; top bits sign-extend into upper half
                    r_nxt.wr_data = prod + {{6{r_r.ppb[17]}}, r_r.ppb[17:8]};
                    r_nxt.wr_en = !(r_r.dst == cmau_pkg::CMAU_AUX_REG);
                    if (!r_r.fract) begin
                        r_nxt.aux_wr_en = 1'b1;
                        r_nxt.aux_wr_data = (r_r.dst == cmau_pkg::CMAU_AUX_REG)
                                          ? r_nxt.wr_data : r_nxt.aux;
                    end
                end else if (r_r.slow) begin
                    r_nxt.wcnt = cmau_pkg::CMAU_SLOW_WAIT;
                    r_nxt.st = cmau_pkg::CMAU_ST_WAIT;
                end else begin
                    r_nxt.st = r_nxt.ret;
                end
            end
        endcase
        if (!rstn) begin
            r_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        r_r <= r_nxt;
    end

    assign busy = r_r.busy;
    assign done = r_r.done;
    assign wr_en = r_r.wr_en;
    assign wr_addr = r_r.wr_addr;
    assign wr_data = r_r.wr_data;
    assign aux_wr_en = r_r.aux_wr_en;
    assign aux_wr_data = r_r.aux_wr_data;
    assign src_idx = r_r.src_idx;
    assign dst_idx = r_r.dst_idx;
    assign status_flags = r_r.flags;

    AST_FMUL_AUX: assert property (@(posedge clk) disable iff (!rstn)
        done && $past(busy) && r_r.fract
        |-> !aux_wr_en && !(wr_en && wr_addr == cmau_pkg::CMAU_AUX_REG))
        else $error("fractional multiply wrote aux");
    AST_BYTE_ONE: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && !busy && op_code == cmau_pkg::CMAU_OP_UMUL |=> done && wr_en)
        else $error("byte multiply not single pass");
    AST_LONG_FAST: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && !busy && op_code == cmau_pkg::CMAU_OP_LMUL
        && core_config_register[cmau_pkg::CMAU_CFG_SPEED_BIT] |=> busy [*4] ##1 done)
        else $error("long multiply not four passes");
    AST_PPB_CLR: assert property (@(posedge clk) disable iff (!rstn)
        r_r.st == cmau_pkg::CMAU_ST_P1 |-> r_r.ppb == 18'h00000)
        else $error("partial product buffer not cleared");
    AST_LONG_DEST: assert property (@(posedge clk) disable iff (!rstn)
        done && busy == 1'b0 && $past(busy) && r_r.dst != cmau_pkg::CMAU_AUX_REG
        |-> wr_en && wr_addr == r_r.dst)
        else $error("long result not written");
    AST_ADD_FLAGS: assert property (@(posedge clk) disable iff (!rstn)
        $past(op_valid && !busy && op_code == cmau_pkg::CMAU_OP_ADD) && !$past(alternate_mode_flag_one_prefix)
        |-> status_flags[0] == (wr_data == 16'h0000) && !status_flags[8])
        else $error("add flags wrong");
    AST_ADD_NOCARRY: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && !busy && op_code == cmau_pkg::CMAU_OP_ADD
        |=> wr_data == $past(src_value) + $past(operand_value))
        else $error("plain add used carry");
    AST_DEFAULT_REG: assert property (@(posedge clk) disable iff (!rstn)
        !dst_sel_valid |=> dst_idx == 4'h0)
        else $error("destination did not default");
    AST_ALTERNATE_MODE_FLAG_ONE: assert property (@(posedge clk) disable iff (!rstn)
        alternate_mode_flag_one_prefix |=> status_flags[8])
        else $error("alt flag not set");
    COV_LMUL: cover property (@(posedge clk) busy ##[1:12] done && aux_wr_en);
    COV_ADD: cover property (@(posedge clk) done && !busy && status_flags[1]);
    COV_SLOW: cover property (@(posedge clk) r_r.st == cmau_pkg::CMAU_ST_WAIT);

endmodule // cmau_unit
